/* File: verilog/scg_regbank.v */
`timescale 1ns/1ps
`include "scg_regs.vh"
// Summary of operation
// - accept ancillary data only on ID match
// - parity bit stored, never used
// - frequency word from four bytes, 08h MSB
// - upper bytes shadowed, 0Bh write commits when auto load is off
// - sixteen-bit phase offset from 0Ch/0Dh
// - port write drives, read returns pins
// - direction bit one means output
// - pins 7,6,1,0 shared with alternates
// - auto load takes frequency from stream
module scg_regbank (
    clk_sys,
    rst,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata_q,
    auto_freq_load_enable,
    anc_valid,
    anc_data_id,
    anc_freq_valid,
    anc_freq_word,
    anc_accept_q,
    subcarrier_freq_word_q,
    freq_update_q,
    subcarrier_phase_offset_q,
    ancillary_id_bits_q,
    alt_sel,
    alt_out,
    alt_oe,
    pin_in,
    pin_out_q,
    pin_oe_q
);
    input  wire        clk_sys;
    input  wire        rst;
    input  wire [7:0]  reg_addr;                  // register index
    input  wire        reg_wr;                    // write strobe
    input  wire        reg_rd;                    // read strobe
    input  wire [7:0]  reg_wdata;                 // write data
    output reg  [7:0]  reg_rdata_q;               // read data
    input  wire        auto_freq_load_enable;     // stream loads frequency
    input  wire        anc_valid;                 // ancillary packet header valid
    input  wire [7:0]  anc_data_id;               // packet data id
    input  wire        anc_freq_valid;            // frequency word from stream
    input  wire [31:0] anc_freq_word;             // stream frequency value
    output reg         anc_accept_q;              // packet is for us
    output reg  [31:0] subcarrier_freq_word_q;    // to synthesizer
    output reg         freq_update_q;             // one-cycle new word pulse
    output reg  [15:0] subcarrier_phase_offset_q; // to phase logic
    output reg  [6:0]  ancillary_id_bits_q;       // id to parser
    input  wire [7:0]  alt_sel;                   // alternate owns pin
    input  wire [7:0]  alt_out;                   // alternate drive value
    input  wire [7:0]  alt_oe;                    // alternate drive enable
    input  wire [7:0]  pin_in;                    // raw pin levels
    output wire [7:0]  pin_out_q;                 // pin data (flopped in leaf)
    output wire [7:0]  pin_oe_q;                  // pin enable (flopped in leaf)

    // ****************************************
    // storage
    // ****************************************
    reg  [7:0] anc_id_q;       // full id byte incl. parity
    reg  [7:0] shadow_b3_q;    // frequency shadow, msb
    reg  [7:0] shadow_b2_q;    // frequency shadow
    reg  [7:0] shadow_b1_q;    // frequency shadow
    reg  [7:0] port_data_q;    // port write data
    reg  [7:0] port_dir_q;     // port direction
    wire [7:0] pin_level;      // synchronised pin levels

    // compare the seven id bits, ignoring bit 0
    function id_match;
        input [7:0] prog;
        input [7:0] seen;
        begin
            id_match = (prog[`SCG_ANC_ID_MSB:`SCG_ANC_ID_LSB] ==
                        seen[`SCG_ANC_ID_MSB:`SCG_ANC_ID_LSB]);
        end
    endfunction

    // ****************************************
    // register writes
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            anc_id_q                  <= `SCG_RST_BYTE;
            shadow_b3_q               <= `SCG_RST_BYTE;
            shadow_b2_q               <= `SCG_RST_BYTE;
            shadow_b1_q               <= `SCG_RST_BYTE;
            subcarrier_freq_word_q    <= `SCG_RST_WORD;
            freq_update_q             <= 1'b0;
            subcarrier_phase_offset_q <= `SCG_RST_HALF;
            port_data_q               <= `SCG_RST_BYTE;
            port_dir_q                <= `SCG_RST_DIR;
        end else begin
            freq_update_q <= 1'b0;
            if (auto_freq_load_enable) begin
                if (anc_freq_valid) begin
                    subcarrier_freq_word_q <= anc_freq_word;
                    freq_update_q          <= 1'b1;
                end
            end else if (reg_wr && reg_addr == `SCG_IDX_FREQ_B0) begin
                subcarrier_freq_word_q <= {shadow_b3_q, shadow_b2_q, shadow_b1_q, reg_wdata};
                freq_update_q          <= 1'b1;
            end
            if (reg_wr) begin
                case (reg_addr)
                    `SCG_IDX_ANC_ID:    anc_id_q <= reg_wdata;
                    `SCG_IDX_FREQ_B3:   shadow_b3_q <= reg_wdata;
                    `SCG_IDX_FREQ_B2:   shadow_b2_q <= reg_wdata;
                    `SCG_IDX_FREQ_B1:   shadow_b1_q <= reg_wdata;
                    `SCG_IDX_PHASE_HI:  subcarrier_phase_offset_q[15:8] <= reg_wdata;
                    `SCG_IDX_PHASE_LO:  subcarrier_phase_offset_q[7:0]  <= reg_wdata;
                    `SCG_IDX_PORT_DATA: port_data_q <= reg_wdata;
                    `SCG_IDX_PORT_DIR:  port_dir_q <= reg_wdata;
                    default:            port_dir_q <= port_dir_q;
                endcase
            end
        end
    end

    // ****************************************
    // register reads and id filter
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_q         <= `SCG_RST_BYTE;
            anc_accept_q        <= 1'b0;
            ancillary_id_bits_q <= 7'h00;
        end else begin
            ancillary_id_bits_q <= anc_id_q[`SCG_ANC_ID_MSB:`SCG_ANC_ID_LSB];
            anc_accept_q <= anc_valid && id_match(anc_id_q, anc_data_id);
            if (reg_rd) begin
                case (reg_addr)
                    `SCG_IDX_ANC_ID:    reg_rdata_q <= anc_id_q;
                    `SCG_IDX_FREQ_B3:   reg_rdata_q <= shadow_b3_q;
                    `SCG_IDX_FREQ_B2:   reg_rdata_q <= shadow_b2_q;
                    `SCG_IDX_FREQ_B1:   reg_rdata_q <= shadow_b1_q;
                    `SCG_IDX_FREQ_B0:   reg_rdata_q <= subcarrier_freq_word_q[7:0];
                    `SCG_IDX_PHASE_HI:  reg_rdata_q <= subcarrier_phase_offset_q[15:8];
                    `SCG_IDX_PHASE_LO:  reg_rdata_q <= subcarrier_phase_offset_q[7:0];
                    `SCG_IDX_PORT_DATA: reg_rdata_q <= pin_level;
                    `SCG_IDX_PORT_DIR:  reg_rdata_q <= port_dir_q;
                    default:            reg_rdata_q <= `SCG_UNMAPPED_DATA;
                endcase
            end
        end
    end

    // ****************************************
    // port pins
    // ****************************************
    scg_port_pins u_pins (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .port_dir_q  (port_dir_q),
        .port_out_q  (port_data_q),
        .alt_sel     (alt_sel),
        .alt_out     (alt_out),
        .alt_oe      (alt_oe),
        .pin_in      (pin_in),
        .pin_out_q   (pin_out_q),
        .pin_oe_q    (pin_oe_q),
        .pin_level_q (pin_level)
    );
endmodule

/* File: shared/scg_regs.vh */
`ifndef SCG_REGS_VH
`define SCG_REGS_VH
// ****************************************
// register indices
// ****************************************
`define SCG_IDX_ANC_ID      8'h07
`define SCG_IDX_FREQ_B3     8'h08
`define SCG_IDX_FREQ_B2     8'h09
`define SCG_IDX_FREQ_B1     8'h0A
`define SCG_IDX_FREQ_B0     8'h0B
`define SCG_IDX_PHASE_HI    8'h0C
`define SCG_IDX_PHASE_LO    8'h0D
`define SCG_IDX_PORT_DATA   8'h0E
`define SCG_IDX_PORT_DIR    8'h0F
// ****************************************
// field positions and reset values
// ****************************************
`define SCG_ANC_ID_MSB      7
`define SCG_ANC_ID_LSB      1
`define SCG_ANC_PARITY_BIT  0
`define SCG_RST_BYTE        8'h00
`define SCG_RST_WORD        32'h0000_0000
`define SCG_RST_HALF        16'h0000
`define SCG_RST_DIR         8'h00
`define SCG_UNMAPPED_DATA   8'h00
`endif

/* File: verilog/scg_port_pins.v */
`timescale 1ns/1ps
`include "scg_regs.vh"
// ****************************************
// eight-pin port with alternate functions
// ****************************************
module scg_port_pins (
    clk_sys,
    rst,
    port_dir_q,
    port_out_q,
    alt_sel,
    alt_out,
    alt_oe,
    pin_in,
    pin_out_q,
    pin_oe_q,
    pin_level_q
);
    input  wire       clk_sys;
    input  wire       rst;
    input  wire [7:0] port_dir_q;   // 1 = output
    input  wire [7:0] port_out_q;   // written data
    input  wire [7:0] alt_sel;      // pin given to alternate function
    input  wire [7:0] alt_out;      // alternate function drive value
    input  wire [7:0] alt_oe;       // alternate function drive enable
    input  wire [7:0] pin_in;       // raw pin levels
    output reg  [7:0] pin_out_q;    // value put on pins
    output reg  [7:0] pin_oe_q;     // high while driving
    output reg  [7:0] pin_level_q;  // synchronised pin levels

    // only pins 7, 6, 1, 0 may be handed over
    localparam [7:0] SHARED_MASK = 8'hC3;

    reg  [7:0] sync1_q;             // first sync stage
    wire [7:0] use_alt;             // alternate function owns pin

    assign use_alt = alt_sel & SHARED_MASK;

    // ****************************************
    // pin drive and sampling
    // ****************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_out_q   <= `SCG_RST_BYTE;
            pin_oe_q    <= `SCG_RST_DIR;
            sync1_q     <= `SCG_RST_BYTE;
            pin_level_q <= `SCG_RST_BYTE;
        end else begin
            pin_out_q   <= (use_alt & alt_out) | (~use_alt & port_out_q);
            pin_oe_q    <= (use_alt & alt_oe) | (~use_alt & port_dir_q);
            sync1_q     <= pin_in;
            pin_level_q <= sync1_q;
        end
    end
endmodule

/* File: verification/scg_regbank_monitor.sv */
`timescale 1ns/1ps
// ****************************************
// port checker for the register slice
// ****************************************
module scg_regbank_monitor (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        auto_freq_load_enable,
    input wire logic        anc_valid,
    input wire logic [7:0]  anc_data_id,
    input wire logic        anc_freq_valid,
    input wire logic [31:0] anc_freq_word,
    input wire logic        anc_accept_q,
    input wire logic [31:0] subcarrier_freq_word_q,
    input wire logic        freq_update_q,
    input wire logic [15:0] subcarrier_phase_offset_q,
    input wire logic [6:0]  ancillary_id_bits_q,
    input wire logic [7:0]  pin_oe_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // host write to a given index
    sequence host_wr(a); reg_wr && reg_addr == a; endsequence
    // low byte write that commits the word
    sequence host_commit; host_wr(8'h0B) ##0 !auto_freq_load_enable && !anc_freq_valid; endsequence
    a_reset_clear: assert property ($fell(rst) |-> pin_oe_q == 8'h00 && subcarrier_freq_word_q == 32'h0
        && subcarrier_phase_offset_q == 16'h0 && ancillary_id_bits_q == 7'h0) else $error("reset values wrong");
    a_word_holds: assert property (!freq_update_q |-> $stable(subcarrier_freq_word_q))
        else $error("word moved without update");
    a_host_commit: assert property (host_commit |=> freq_update_q
        && subcarrier_freq_word_q[7:0] == $past(reg_wdata)) else $error("low byte commit wrong");
    a_auto_ignore: assert property (host_wr(8'h0B) ##0 auto_freq_load_enable && !anc_freq_valid
        |=> !freq_update_q) else $error("host commit taken in auto mode");
    a_stream_load: assert property (auto_freq_load_enable && anc_freq_valid
        |=> freq_update_q && subcarrier_freq_word_q == $past(anc_freq_word)) else $error("stream load wrong");
    a_phase_low: assert property (host_wr(8'h0D) |=> subcarrier_phase_offset_q[7:0] == $past(reg_wdata))
        else $error("phase low byte wrong");
    a_id_bits: assert property (host_wr(8'h07) |-> ##2 ancillary_id_bits_q == $past(reg_wdata[7:1], 2))
        else $error("id bits wrong");
    a_dir_oe: assert property (host_wr(8'h0F) |-> ##2 pin_oe_q[5:2] == $past(reg_wdata[5:2], 2))
        else $error("pin enable wrong");
    a_accept_cause: assert property (anc_accept_q |-> $past(anc_valid)
        && $past(anc_data_id[7:1]) == $past(ancillary_id_bits_q)) else $error("accept without match");
endmodule
bind scg_regbank scg_regbank_monitor scg_regbank_monitor_inst (.clk_sys, .rst, .reg_addr, .reg_wr, .reg_wdata,
    .auto_freq_load_enable, .anc_valid, .anc_data_id, .anc_freq_valid, .anc_freq_word, .anc_accept_q,
    .subcarrier_freq_word_q, .freq_update_q, .subcarrier_phase_offset_q, .ancillary_id_bits_q, .pin_oe_q);

/* File: verification/test_subcarrier_and_gpio_registers.sv */
`timescale 1ns/1ps
// ****************************************
// register slice bench
// ****************************************
module test_subcarrier_and_gpio_registers;
    reg clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, auto_en = 1'b0, anc_v = 1'b0, anc_fv = 1'b0;
    reg  [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, anc_id = 8'h00, alt_sel = 8'h00, alt_oe = 8'h00;
    reg  [7:0]  alt_out = 8'h00, ext = 8'h5A;   // ext: outside world level
    reg  [31:0] anc_word = 32'h0;
    reg  [23:0] rows [0:8];                     // index, write data, read back
    wire [7:0]  rdata, pin_out, pin_oe;
    wire [31:0] word;
    wire [15:0] phase;
    wire        acc, upd;
    wire [7:0]  pin_in = (pin_out & pin_oe) | (ext & ~pin_oe); // resolved pin level
    integer     miscompares = 0, checks_done = 0, i;
    scg_regbank scg_regbank_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .auto_freq_load_enable(auto_en),
        .anc_valid(anc_v), .anc_data_id(anc_id), .anc_freq_valid(anc_fv), .anc_freq_word(anc_word),
        .anc_accept_q(acc), .subcarrier_freq_word_q(word), .freq_update_q(upd),
        .subcarrier_phase_offset_q(phase), .ancillary_id_bits_q(), .alt_sel(alt_sel), .alt_out(alt_out),
        .alt_oe(alt_oe), .pin_in(pin_in), .pin_out_q(pin_out), .pin_oe_q(pin_oe));
    always #50 clk_sys = ~clk_sys;
    task chk(input [63:0] got, input [63:0] exp); begin
        checks_done = checks_done + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    end endtask
    task wr(input [7:0] a, input [7:0] d); begin
        @(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk_sys); reg_wr <= 1'b0;
        #1;
    end endtask
    task rd(input [7:0] a, input [7:0] exp); begin
        @(posedge clk_sys); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk_sys); reg_rd <= 1'b0;
        #1 chk(rdata, exp);
    end endtask
    // one ancillary header, then look at the accept flag
    task anc(input [7:0] id, input e); begin
        @(posedge clk_sys); anc_v <= 1'b1; anc_id <= id;
        @(posedge clk_sys); anc_v <= 1'b0;
        #1 chk(acc, e);
    end endtask
    task print_verdict; begin
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end endtask
    initial begin
        rows[0] = 24'h07A5A5; rows[1] = 24'h081212; rows[2] = 24'h093434; rows[3] = 24'h0A5656;
        rows[4] = 24'h0C9A9A; rows[5] = 24'h0DBCBC; rows[6] = 24'h0F3C3C; rows[7] = 24'h107700;
        rows[8] = 24'h067700;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1 chk({word, phase, pin_oe}, 56'h0);
        rd(8'h0F, 8'h00);
        for (i = 0; i < 9; i = i + 1) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk(word, 32'h0);
        chk(phase, 16'h9ABC);
        wr(8'h0C, 8'h00);
        wr(8'h0D, 8'h00);
        chk(phase, 16'h0000);
        wr(8'h0B, 8'h78);
        chk(word, 32'h12345678);
        rd(8'h0B, 8'h78);
        wr(8'h0E, 8'hF0);
        repeat (4) @(posedge clk_sys);
        #1 chk(pin_oe, 8'h3C);
        chk(pin_out & pin_oe, 8'h30);
        rd(8'h0E, 8'h72);
        anc(8'hA4, 1'b1);
        anc(8'hA7, 1'b0);
        anc(8'hA5, 1'b1);
        @(posedge clk_sys); auto_en <= 1'b1;
        wr(8'h0B, 8'h11);
        chk({upd, word}, {1'b0, 32'h12345678});
        @(posedge clk_sys); anc_fv <= 1'b1; anc_word <= 32'hDEADBEEF;
        @(posedge clk_sys); anc_fv <= 1'b0;
        #1 chk({upd, word}, {1'b1, 32'hDEADBEEF});
        @(posedge clk_sys); alt_sel <= 8'h81; alt_oe <= 8'h81; alt_out <= 8'h01;
        repeat (3) @(posedge clk_sys);
        #1 chk({pin_oe[7], pin_oe[0], pin_out[7], pin_out[0]}, 4'b1101);
        @(posedge clk_sys); rst <= 1'b1;
        @(posedge clk_sys); rst <= 1'b0;
        #1 chk({word, phase}, 48'h0);
        rd(8'h0F, 8'h00);
        print_verdict;
    end
    // watchdog against a hung sequence
    initial begin
        #300000;
        miscompares = miscompares + 1;
        print_verdict;
    end
endmodule
